/* hw/cie_defs.vh */
// register offsets, field positions, reset values and timing counts of the command/irq enable block
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH
`define CIE_ADDR_W 4
`define CIE_OFS_RSVD 4'h0
`define CIE_OFS_CMD 4'h1
`define CIE_OFS_MAIN_EN 4'h2
`define CIE_OFS_AUX_EN 4'h3
`define CIE_OFS_REQ_STAT 4'h4
`define CIE_OFS_REQ_MASK 4'h5
`define CIE_RST_RSVD 8'h00
`define CIE_RST_CMD 8'h20
`define CIE_RST_MAIN_EN 8'h80
`define CIE_RST_AUX_EN 8'h00
`define CIE_RST_REQ_MASK 8'h00
`define CIE_BIT_RCV_OFF 5
`define CIE_BIT_PWR_DOWN 4
`define CIE_BIT_POL_INV 7
`define CIE_BIT_DRIVE_SEL 7
`define CIE_BIT_EXT_SER 4
`define CIE_BIT_CHKSUM 2
`define CIE_CMD_MASK 8'h3F
`define CIE_MAIN_MASK 8'hFF
`define CIE_AUX_MASK 8'h94
`define CIE_CODE_IDLE 4'h0
`define CIE_CODE_REINIT 4'hF
`define CIE_WAKE_NS 1000
`define CIE_CLK_MHZ 40
`define CIE_WAKE_CYC ((`CIE_WAKE_NS * `CIE_CLK_MHZ + 999) / 1000)
`endif

/* hw/cie_sync.v */
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cie_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_ce,
  input wire i_reset_n,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else if (i_ce) begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule
`default_nettype wire

/* hw/cie_top.v */
// command register, interrupt enable registers and interrupt pin drive
// Summary of operation
// - address zero reads zero, all reserved
// - command register at one, resets 20h
// - receiver_off bit switches receiver off
// - writing one enters soft power-down
// - clearing reads one until wake-up done
// - power-down ignored while reinit command active
// - command code write starts, read shows running
// - command field returns idle when finished
// - main enable at two, resets 80h
// - bit seven inverts interrupt pin polarity
// - reset defaults leave pin tristate
// - bits six to four gate tx/rx/done
// - bits three to zero gate fifo/error/timer
// - aux enable at three, resets 00h
// - aux bit seven selects push-pull drive
// - aux bit four gates serial-input activity
// - aux bit two gates checksum done
`timescale 1ns/1ps
`default_nettype none
`include "cie_defs.vh"
module cie_top #(
  parameter WAKE_CYC = `CIE_WAKE_CYC
) (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_CE,
  input wire [3:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  input wire [6:0] I_MAIN_REQ,
  input wire I_CHECKSUM_REQUEST,
  input wire I_EXT_SERIAL_INPUT,
  input wire I_CMD_FINISHED,
  output reg [3:0] O_CMD_CODE,
  output reg O_CMD_START,
  output reg O_RECEIVER_OFF,
  output reg O_POWER_DOWN,
  output reg O_IRQ_STATUS,
  output reg O_IRQ_OUT,
  output reg O_IRQ_OE,
  output reg O_INT
);
  // ==========================================================
  // input synchronisers
  wire ser_s;
  wire [7:0] main_req_s;
  wire chk_s;
  cie_sync #(.W(10)) u_sync (
    .i_clk(I_CLK),
    .i_ce(I_CE),
    .i_reset_n(I_RESET_N),
    .i_d({I_EXT_SERIAL_INPUT, I_CHECKSUM_REQUEST, I_MAIN_REQ, 1'b0}),
    .o_q({ser_s, chk_s, main_req_s})
  );

  // ==========================================================
  // registers
  reg [1:0] cmd_hi_r;
  reg [3:0] cmd_code_r;
  reg pd_r;
  reg waking_r;
  reg [15:0] wake_cnt_r;
  reg [7:0] main_en_r;
  reg [7:0] aux_en_r;
  reg [7:0] req_stat_r;
  reg [7:0] req_mask_r;
  reg ser_d_r;
  wire wr_cmd = I_WR && (I_ADDR == `CIE_OFS_CMD);
  wire [7:0] cmd_rst = `CIE_RST_CMD;
  wire [7:0] aux_req = {3'h0, ser_s ^ ser_d_r, 1'b0, chk_s, 2'h0};
  wire [7:0] events = {main_req_s[7:1], 1'b0} | {aux_req[4], aux_req[2], 6'h00};

  function [7:0] rd_mux;
    input [3:0] a;
    input [7:0] c;
    input [7:0] m;
    input [7:0] x;
    input [7:0] s;
    input [7:0] k;
    begin
      case (a)
        `CIE_OFS_CMD: rd_mux = c;
        `CIE_OFS_MAIN_EN: rd_mux = m;
        `CIE_OFS_AUX_EN: rd_mux = x;
        `CIE_OFS_REQ_STAT: rd_mux = s;
        `CIE_OFS_REQ_MASK: rd_mux = k;
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // command register and power-down sequence
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      cmd_hi_r <= cmd_rst[6:5];
      cmd_code_r <= `CIE_CODE_IDLE;
      pd_r <= cmd_rst[`CIE_BIT_PWR_DOWN];
      waking_r <= 1'b0;
      wake_cnt_r <= 16'h0000;
      O_CMD_START <= 1'b0;
    end else if (I_CE) begin
      O_CMD_START <= 1'b0;
      if (waking_r) begin
        if (wake_cnt_r == 16'h0000) begin
          waking_r <= 1'b0;
          pd_r <= 1'b0;
        end else begin
          wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
      end
      if (wr_cmd) begin
        cmd_hi_r <= {1'b0, I_WDATA[`CIE_BIT_RCV_OFF]};
        cmd_code_r <= I_WDATA[3:0];
        O_CMD_START <= 1'b1;
        if (I_WDATA[`CIE_BIT_PWR_DOWN]) begin
          if (cmd_code_r != `CIE_CODE_REINIT) begin
            pd_r <= 1'b1;
            waking_r <= 1'b0;
          end
        end else if (pd_r && !waking_r) begin
          waking_r <= 1'b1;
          wake_cnt_r <= WAKE_CYC[15:0] - 16'h0001;
        end
      end else if (I_CMD_FINISHED) begin
        cmd_code_r <= `CIE_CODE_IDLE;
      end
    end
  end

  // ==========================================================
  // enable, status and mask registers
  integer i;
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      main_en_r <= `CIE_RST_MAIN_EN;
      aux_en_r <= `CIE_RST_AUX_EN;
      req_stat_r <= 8'h00;
      req_mask_r <= `CIE_RST_REQ_MASK;
      ser_d_r <= 1'b0;
    end else if (I_CE) begin
      ser_d_r <= ser_s;
      if (I_WR && I_ADDR == `CIE_OFS_MAIN_EN)
        main_en_r <= I_WDATA & `CIE_MAIN_MASK;
      if (I_WR && I_ADDR == `CIE_OFS_AUX_EN)
        aux_en_r <= I_WDATA & `CIE_AUX_MASK;
      if (I_WR && I_ADDR == `CIE_OFS_REQ_MASK)
        req_mask_r <= I_WDATA;
      for (i = 0; i < 8; i = i + 1) begin
        if (events[i])
          req_stat_r[i] <= 1'b1;
        else if (I_WR && I_ADDR == `CIE_OFS_REQ_STAT && I_WDATA[i])
          req_stat_r[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt pin and outputs
  wire main_hit = |(main_req_s[7:1] & main_en_r[6:0]);
  wire aux_hit = (aux_req[`CIE_BIT_EXT_SER] & aux_en_r[`CIE_BIT_EXT_SER])
    | (aux_req[`CIE_BIT_CHKSUM] & aux_en_r[`CIE_BIT_CHKSUM]);
  wire irq_nxt = main_hit | aux_hit;
  wire pin_lvl = irq_nxt ^ main_en_r[`CIE_BIT_POL_INV];
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
      O_IRQ_STATUS <= 1'b0;
      O_IRQ_OUT <= 1'b0;
      O_IRQ_OE <= 1'b0;
      O_INT <= 1'b0;
      O_CMD_CODE <= `CIE_CODE_IDLE;
      O_RECEIVER_OFF <= 1'b1;
      O_POWER_DOWN <= 1'b0;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? rd_mux(I_ADDR, {1'b0, cmd_hi_r, pd_r, cmd_code_r}, main_en_r, aux_en_r,
        req_stat_r, req_mask_r) : 8'h00;
      O_IRQ_STATUS <= irq_nxt;
      O_IRQ_OUT <= aux_en_r[`CIE_BIT_DRIVE_SEL] ? pin_lvl : 1'b0;
      O_IRQ_OE <= aux_en_r[`CIE_BIT_DRIVE_SEL] | ~pin_lvl;
      O_INT <= |(req_stat_r & req_mask_r);
      O_CMD_CODE <= cmd_code_r;
      O_RECEIVER_OFF <= cmd_hi_r[0];
      O_POWER_DOWN <= pd_r;
    end
  end
endmodule
`default_nettype wire

/* sim/cie_host.sv */
// host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module cie_host (
  input wire logic i_clk,
  output var logic [3:0] o_addr,
  output var logic [7:0] o_wdata,
  output var logic o_wr,
  output var logic o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/cie_top_asserts.sv */
// checker for the command and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module cie_top_asserts #(
  parameter WAKE_CYC = 40
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_CMD_FINISHED,
  input wire logic [7:0] O_RDATA,
  input wire logic [3:0] O_CMD_CODE,
  input wire logic O_CMD_START,
  input wire logic O_RECEIVER_OFF,
  input wire logic O_POWER_DOWN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire cmd_wr = I_WR && I_ADDR == 4'h1;
  wire pd_wr = cmd_wr && I_WDATA[4];
  // code output lags the live code by one cycle after a write or finish
  logic code_fresh;
  always @(posedge I_CLK) code_fresh <= !cmd_wr && !I_CMD_FINISHED;
  // ========================================
  // assertions
  a_rsvd_reads_zero: assert property (I_RD && I_ADDR == 4'h0 |=> O_RDATA == 8'h00)
    else $error("reserved register not zero");
  a_cmd_rsvd_zero: assert property (I_RD && I_ADDR == 4'h1 |=> O_RDATA[7:6] == 2'b00)
    else $error("command reserved bits set");
  a_aux_rsvd_zero: assert property (I_RD && I_ADDR == 4'h3 |=> (O_RDATA & 8'h6B) == 8'h00)
    else $error("aux reserved bits set");
  a_rcv_off_follows: assert property (cmd_wr |-> ##2 O_RECEIVER_OFF == $past(I_WDATA[5], 2))
    else $error("receiver off not following write");
  a_pd_enter: assert property (pd_wr && code_fresh && O_CMD_CODE != 4'hF |-> ##2 O_POWER_DOWN)
    else $error("power down not entered");
  a_pd_refused: assert property (pd_wr && code_fresh && O_CMD_CODE == 4'hF && !O_POWER_DOWN |-> ##2 !O_POWER_DOWN)
    else $error("power down taken during reinit");
  a_wake_hold: assert property ($fell(O_POWER_DOWN) |-> $past(O_POWER_DOWN, WAKE_CYC))
    else $error("wake up too short");
  a_cmd_start: assert property (cmd_wr |-> ##[1:2] O_CMD_START)
    else $error("command start missing");
  // ========================================
  // covers
  c_pd: cover property (O_POWER_DOWN);
  c_pd_wr: cover property (pd_wr);
  c_start: cover property (O_CMD_START);
endmodule
bind cie_top cie_top_asserts #(.WAKE_CYC(WAKE_CYC)) u_chk (.*);
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the command and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, ck = 0, ser = 0, cf = 0, rdv = 0, ce = 1;
  logic [6:0] req = 0;
  logic [7:0] v;
  logic [7:0] q[$];
  int n_fail = 0, num_checks = 0;
  wire [3:0] addr;
  wire [7:0] wd, rdata;
  wire wr, rd, rcv, pd, st, io, oe, intr;
  cie_top #(.WAKE_CYC(4)) dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wd),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_MAIN_REQ(req), .I_CHECKSUM_REQUEST(ck), .I_EXT_SERIAL_INPUT(ser),
    .I_CMD_FINISHED(cf), .O_CMD_CODE(), .O_CMD_START(), .O_RECEIVER_OFF(rcv), .O_POWER_DOWN(pd),
    .O_IRQ_STATUS(st), .O_IRQ_OUT(io), .O_IRQ_OE(oe), .O_INT(intr));
  cie_host h (.i_clk(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic rx(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    h.rd(a);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic fin_cmd();
    cf <= 1'b1;
    wt(1);
    cf <= 1'b0;
  endtask
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ========================================
  // read answers against noted expectations
  always @(posedge clk) begin
    if (rdv) chk(rdata, q.pop_front());
    rdv <= rd;
  end
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  // ========================================
  // scenarios
  initial begin
    void'($urandom(32'hECA7));
    wt(6);
    rst_n <= 1'b1;
    rx(0, 8'h00);
    rx(1, 8'h20);
    rx(2, 8'h80);
    rx(3, 8'h00);
    rx(6, 8'h00);
    chk(oe, 0);
    h.wr(0, 8'hFF);
    rx(0, 8'h00);
    v = $urandom;
    h.wr(2, v);
    rx(2, v);
    v = $urandom;
    h.wr(3, v);
    rx(3, v & 8'h94);
    h.wr(1, 8'hC3);
    rx(1, 8'h03);
    chk(rcv, 0);
    fin_cmd();
    rx(1, 8'h00);
    h.wr(1, 8'h10);
    rx(1, 8'h10);
    h.wr(1, 8'h00);
    rx(1, 8'h10);
    wt(8);
    rx(1, 8'h00);
    h.wr(1, 8'h0F);
    rx(1, 8'h0F);
    h.wr(1, 8'h1F);
    rx(1, 8'h0F);
    chk(pd, 0);
    fin_cmd();
    h.wr(3, 8'h00);
    for (int k = 0; k < 7; k++) begin
      req <= 7'h01 << k;
      h.wr(2, 8'h00);
      wt(4);
      chk(st, 0);
      h.wr(2, 8'h01 << k);
      wt(4);
      chk(st, 1);
    end
    chk(oe, 0);
    h.wr(3, 8'h80);
    wt(3);
    chk({oe, io}, 2'b11);
    h.wr(2, 8'hC0);
    wt(3);
    chk(io, 0);
    req <= 7'h00;
    h.wr(2, 8'h00);
    h.wr(3, 8'h04);
    ck <= 1'b1;
    wt(5);
    chk(st, 1);
    ck <= 1'b0;
    h.wr(3, 8'h10);
    h.wr(5, 8'h00);
    wt(3);
    h.wr(4, 8'hFF);
    ser <= 1'b1;
    wt(5);
    chk(intr, 0);
    h.wr(5, 8'hFF);
    wt(3);
    chk(intr, 1);
    h.wr(4, 8'hFF);
    wt(3);
    chk(intr, 0);
    ce <= 1'b0;
    h.wr(2, 8'h55);
    ce <= 1'b1;
    rx(2, 8'h00);
    wt(2);
    conclude();
  end
endmodule
`default_nettype wire
